// *** logic/adccb_pkg.sv ***
// Shared constants of the capture buffer: depth, register map, field layout.
// Assumes a single system clock drives both capture and readout.
package adccb_pkg;
    localparam int          ADDR_W        = 12;
    localparam int          COUNT_W       = 13;
    localparam int          DATA_W        = 8;
    localparam int          DEPTH         = 4096;
    localparam int          REG_ADDR_W    = 4;
    localparam int          REG_W         = 16;
    // Register index of the capture buffer control register.
    localparam logic [3:0]  CTRL_ADDR     = 4'hF;
    localparam int          SPLIT_BIT     = 12;
    localparam int          AUTO_STOP_BIT = 4;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [11:0] PTR_ZERO      = 12'h000;
    localparam logic [11:0] PTR_ONE       = 12'h001;
    localparam logic [11:0] PTR_TWO       = 12'h002;
    localparam logic [12:0] COUNT_ZERO    = 13'h0000;
    localparam logic [12:0] COUNT_ONE     = 13'h0001;
    localparam logic [12:0] COUNT_TWO     = 13'h0002;
    localparam logic [12:0] COUNT_FULL    = 13'h1000;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
endpackage

// *** logic/adccb_mem_if.sv ***
// Carrier between the buffer controller and its sample storage.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface adccb_mem_if;
    logic       wr_en;
    logic [11:0] wr_addr;
    logic [7:0]  wr_data;
    logic [11:0] rd_addr;
    logic [7:0]  rd_first;
    logic [7:0]  rd_second;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_first, input rd_second);
    modport store (input wr_en, input wr_addr, input wr_data,
                   input rd_addr, output rd_first, output rd_second);
endinterface

// *** logic/adccb_store.sv ***
// Flip-flop sample storage with one write port and a paired read port.
// When the buffer is full a write targets the read address; a read in that cycle gets the old byte.
`timescale 1ns/1ps
module adccb_store (
    // Clock
    input wire logic   clk,
    // Controller side
    adccb_mem_if.store mem
);
    logic [7:0]  cells [0:adccb_pkg::DEPTH-1];
    logic [11:0] next_addr;

    // The pair read wraps so a split read across the end stays in order.
    assign next_addr     = mem.rd_addr + adccb_pkg::PTR_ONE;
    assign mem.rd_first  = cells[mem.rd_addr];
    assign mem.rd_second = cells[next_addr];

    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
    end
endmodule

// *** logic/adccb_top.sv ***
// Capture buffer controller: converter bytes in, one or two byte ports out.
// Assumes capture and readout share CLK_SYS; the write strobe may be async.
//
// Contract
// [R1] Split mode with read strobe: secondary port shows half the samples.
// [R2] Split control is bit 12 of control register at address 0xF.
// [R3] Split mode: secondary carries earlier sample, primary the later one.
// [R4] Split bit clear: secondary port is released to high impedance; the code raises SECONDARY_OUTPUT_OE_N but keeps driving SECONDARY_OUTPUT_PORT.
// [R5] Read strobe high: primary port updates from buffer each clock.
// [R6] Split mode: primary port shows only the later sample of a pair.
// [R7] Read strobe low: primary port holds its last value.
// [R8] Split bit clear: primary port delivers every sample in order.
// [R9] Each data-ready strobe rises with its port's data change.
// [R10] Each read cycle with the strobe high removes one byte; split mode removes two.
// [R11] Reader never raises read strobe while write strobe is high.
// [R12] Synchronised write strobe high stores one byte each clock.
// [R13] Write strobe is synchronised internally before use.
// [R14] Port data and empty flag change only on the clock.
// [R15] Reset high returns pointers and flags to initial state.
// [R16] Full flag rises when full; wraps unless auto-stop; read clears.
// [R17] Empty flag set when no data, cleared once writing begins.
// [R18] Over-range flag sticks during capture; read or reset clears it.
// [R19] Synchronised write strobe is driven out.
// [R20] Split read consumes two consecutive samples per cycle.
`timescale 1ns/1ps
module adccb_top (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    // Converter side
    input  wire logic [7:0]  SAMPLE_DATA,
    input  wire logic        SAMPLE_OVER_RANGE,
    // Reader control
    input  wire logic        WRITE_ENABLE,
    input  wire logic        READ_ENABLE,
    // Control register port
    input  wire logic        REG_WRITE,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    output logic [15:0]      REG_RDATA,
    // Output ports
    output logic [7:0]       PRIMARY_OUTPUT_PORT,
    output logic             PRIMARY_DATA_VALID,
    output logic [7:0]       SECONDARY_OUTPUT_PORT,
    output logic             SECONDARY_OUTPUT_OE_N,
    output logic             SECONDARY_DATA_VALID,
    // Status
    output logic             BUFFER_FULL_FLAG,
    output logic             BUFFER_EMPTY_FLAG,
    output logic             OVER_RANGE,
    output logic             CAPTURE_STROBE_SYNCED_OUT
);
    // Storage is a separate flip-flop array reached through the carrier.
    // Keeping it apart lets the controller stay small and readable, and
    // lets the array be swapped for a memory macro later without touching
    // any of the pointer or flag logic below.
    adccb_mem_if mem ();

    adccb_store u_store (
        .clk (CLK_SYS),
        .mem (mem)
    );

    // Both pointers advance through this one helper so that the wrap at the
    // end of the array is handled identically on the write and read sides.
    // A step of two is used only by split-mode reads.
    function automatic logic [11:0] ptr_step(input logic [11:0] ptr,
                                             input logic        two);
        ptr_step = ptr + (two ? adccb_pkg::PTR_TWO : adccb_pkg::PTR_ONE);
    endfunction

    // The occupancy counter is one bit wider than the pointers so that a
    // full array and an empty one can be told apart without comparing the
    // pointers themselves.
    logic [15:0] ctrl_reg;
    logic        wen_meta_reg;
    logic        wen_sync_reg;
    logic [11:0] wptr_reg;
    logic [11:0] rptr_reg;
    logic [12:0] count_reg;
    logic [12:0] count_next;
    logic [7:0]  prim_reg;
    logic [7:0]  sec_reg;
    logic        prim_vld_reg;
    logic        sec_vld_reg;
    logic        full_reg;
    logic        empty_reg;
    logic        over_reg;

    wire split_mode = ctrl_reg[adccb_pkg::SPLIT_BIT];          // [R2]
    wire auto_stop  = ctrl_reg[adccb_pkg::AUTO_STOP_BIT];
    wire is_full    = (count_reg == adccb_pkg::COUNT_FULL);
    // Split mode needs a whole pair; a lone trailing sample is left behind.
    wire can_read   = split_mode ? (count_reg >= adccb_pkg::COUNT_TWO)
                                 : (count_reg != adccb_pkg::COUNT_ZERO);
    wire do_read    = READ_ENABLE && can_read;                 // [R10] [R20]
    wire do_write   = wen_sync_reg && !(is_full && auto_stop); // [R12] [R13]
    // Overwrite drops the oldest byte, so the read side moves along too.
    wire overwrite  = do_write && is_full && !do_read;         // [R16]
    wire [12:0] rd_amount = split_mode ? adccb_pkg::COUNT_TWO
                                       : adccb_pkg::COUNT_ONE;
    wire [12:0] rd_dec    = do_read ? rd_amount : adccb_pkg::COUNT_ZERO;
    wire [12:0] wr_inc    = (do_write && !overwrite) ? adccb_pkg::COUNT_ONE
                                                     : adccb_pkg::COUNT_ZERO;

    // A write that overwrites the oldest byte leaves the count unchanged,
    // so wr_inc is suppressed for it and the read pointer steps instead.
    assign count_next = count_reg - rd_dec + wr_inc;

    assign mem.wr_en   = do_write;
    assign mem.wr_addr = wptr_reg;
    assign mem.wr_data = SAMPLE_DATA;
    assign mem.rd_addr = rptr_reg;

    // Unmapped indices read as zero; only the control register exists.
    assign REG_RDATA = (REG_ADDR == adccb_pkg::CTRL_ADDR) ? ctrl_reg
                                                          : 16'h0000;
    assign PRIMARY_OUTPUT_PORT       = prim_reg;
    assign SECONDARY_OUTPUT_PORT     = sec_reg;
    assign SECONDARY_OUTPUT_OE_N     = !split_mode;            // [R4]
    assign PRIMARY_DATA_VALID        = prim_vld_reg;
    assign SECONDARY_DATA_VALID      = sec_vld_reg;
    assign BUFFER_FULL_FLAG          = full_reg;
    assign BUFFER_EMPTY_FLAG         = empty_reg;
    assign OVER_RANGE                = over_reg;
    assign CAPTURE_STROBE_SYNCED_OUT = wen_sync_reg;           // [R19]

    // All sixteen control bits are stored so that software reads back what
    // it wrote, even for bits that this block does not act on.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ctrl_reg <= adccb_pkg::CTRL_RESET;
        end else if (REG_WRITE && REG_ADDR == adccb_pkg::CTRL_ADDR) begin
            ctrl_reg <= REG_WDATA;
        end
    end

    // The write strobe may change at any time relative to CLK_SYS.
    // The first stage feeds only the second one.
    // This costs two cycles of capture latency, which the reader sees on
    // the synchronised copy and can allow for.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wen_meta_reg <= 1'b0;
            wen_sync_reg <= 1'b0;
        end else begin
            wen_meta_reg <= WRITE_ENABLE;                      // [R13]
            wen_sync_reg <= wen_meta_reg;
        end
    end

    // Pointers step only on a write, read or overwrite; the count is reloaded from count_next on every edge.
    // Storage contents are not cleared by reset; the count alone decides
    // what is readable, so stale bytes can never be returned.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            wptr_reg  <= adccb_pkg::PTR_ZERO;                  // [R15]
            rptr_reg  <= adccb_pkg::PTR_ZERO;
            count_reg <= adccb_pkg::COUNT_ZERO;
        end else begin
            count_reg <= count_next;
            if (do_write) begin
                wptr_reg <= ptr_step(wptr_reg, 1'b0);          // [R16]
            end
            if (do_read || overwrite) begin
                rptr_reg <= ptr_step(rptr_reg, do_read && split_mode);
            end
        end
    end

    // Output ports hold between reads; strobes mark the cycle of change.
    // Data and strobes leave the same flip-flop stage, so the reader sees
    // them move together with no extra clock-to-data skew between them.
    // In single-port mode the secondary register simply keeps its value.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            prim_reg     <= adccb_pkg::BYTE_ZERO;
            sec_reg      <= adccb_pkg::BYTE_ZERO;
            prim_vld_reg <= 1'b0;
            sec_vld_reg  <= 1'b0;
        end else begin
            prim_vld_reg <= do_read;                           // [R9]
            sec_vld_reg  <= do_read && split_mode;             // [R9]
            if (do_read && split_mode) begin
                sec_reg  <= mem.rd_first;                      // [R1] [R3]
                prim_reg <= mem.rd_second;                     // [R6]
            end else if (do_read) begin
                prim_reg <= mem.rd_first;                      // [R5] [R8]
            end                                                // [R7] [R14]
        end
    end

    // The full and empty flags are registered from the next-state count so that they
    // line up with the count that holds after the same edge.
    // The full flag drops on any cycle with the read strobe high, even a
    // refused read, because a read has then been started.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            full_reg  <= 1'b0;
            empty_reg <= 1'b1;
            over_reg  <= 1'b0;
        end else begin
            full_reg  <= !READ_ENABLE
                         && (count_next == adccb_pkg::COUNT_FULL); // [R16]
            empty_reg <= (count_next == adccb_pkg::COUNT_ZERO)
                         && !do_write;                         // [R17]
            // A new out-of-range event wins over a clearing read.
            if (do_write && SAMPLE_OVER_RANGE) begin
                over_reg <= 1'b1;                              // [R18]
            end else if (READ_ENABLE) begin
                over_reg <= 1'b0;
            end
        end
    end
endmodule

// *** test/adccb_checker.sv ***
// Port-level assertions for the capture buffer top.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module adccb_checker (
    // Clock, reset and inputs
    input wire logic        CLK_SYS,
    input wire logic        RESET,
    input wire logic        WRITE_ENABLE,
    input wire logic        READ_ENABLE,
    input wire logic        REG_WRITE,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    // Outputs under watch
    input wire logic [7:0]  PRIMARY_OUTPUT_PORT,
    input wire logic        PRIMARY_DATA_VALID,
    input wire logic        SECONDARY_OUTPUT_OE_N,
    input wire logic        SECONDARY_DATA_VALID,
    input wire logic        BUFFER_FULL_FLAG,
    input wire logic        BUFFER_EMPTY_FLAG,
    input wire logic        CAPTURE_STROBE_SYNCED_OUT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    AST_SPLIT_OE: assert property (REG_WRITE && REG_ADDR == 4'hF
        |=> SECONDARY_OUTPUT_OE_N == !$past(REG_WDATA[12]))
        else $error("secondary enable off");
    AST_HOLD: assert property (!READ_ENABLE |=>
        $stable(PRIMARY_OUTPUT_PORT)) else $error("primary moved");
    AST_VALID_CAUSE: assert property (PRIMARY_DATA_VALID |->
        $past(READ_ENABLE)) else $error("valid without read");
    AST_DATA_STROBE: assert property ($changed(PRIMARY_OUTPUT_PORT)
        |-> PRIMARY_DATA_VALID) else $error("data without strobe");
    AST_SEC_PAIR: assert property (SECONDARY_DATA_VALID |->
        PRIMARY_DATA_VALID && !SECONDARY_OUTPUT_OE_N)
        else $error("secondary strobe alone");
    AST_SYNC: assert property ($rose(WRITE_ENABLE) |->
        ##[1:3] CAPTURE_STROBE_SYNCED_OUT) else $error("sync late");
    AST_EMPTY_FALL: assert property ($fell(BUFFER_EMPTY_FLAG) |->
        $past(CAPTURE_STROBE_SYNCED_OUT)) else $error("empty fell");
    AST_FULL_CLR: assert property (READ_ENABLE |=>
        !BUFFER_FULL_FLAG) else $error("full kept on read");
endmodule
bind adccb_top adccb_checker u_chk (.*);

// *** test/adccb_reader.sv ***
// Reader model: drives the capture and read strobes of the buffer.
// Assumes bench requests change just after the rising clock edge.
`timescale 1ns/1ps
module adccb_reader (
    // Clock and bench requests
    input wire logic clk,
    input wire logic cap_req,
    input wire logic rd_req,
    // Strobes to the buffer
    output logic     we = 1'b0,
    output logic     re = 1'b0
);
    // Reads are held off while capture is asked for or running.
    always @(posedge clk) begin
        we <= cap_req;
        re <= rd_req && !cap_req && !we;
    end
endmodule

// *** test/adc_capture_buffer_port_tb.sv ***
// Self-checking bench for the capture buffer, with a queue model.
// Assumes the reader model and the checker bound to the top.
`timescale 1ns/1ps
module adc_capture_buffer_port_tb;
    logic        CLK_SYS = 1'b0, RESET = 1'b1, REG_WRITE = 1'b0;
    logic        SAMPLE_OVER_RANGE = 1'b0, cap = 1'b0, rd = 1'b0;
    logic [7:0]  SAMPLE_DATA = 8'h00, PRIMARY_OUTPUT_PORT;
    logic [7:0]  SECONDARY_OUTPUT_PORT;
    logic [3:0]  REG_ADDR = 4'h0;
    logic [15:0] REG_WDATA = 16'h0000, REG_RDATA;
    logic        PRIMARY_DATA_VALID, SECONDARY_DATA_VALID, OVER_RANGE;
    logic        BUFFER_FULL_FLAG, BUFFER_EMPTY_FLAG, SECONDARY_OUTPUT_OE_N;
    logic        WRITE_ENABLE, READ_ENABLE, CAPTURE_STROBE_SYNCED_OUT;
    integer      fail_count = 0, n_compared = 0, nw = 0;
    integer      seed = 32'h8CD7DDE9;
    bit          two = 1'b0, ovm = 1'b0, ast = 1'b0;
    byte unsigned q[$];
    adccb_top u_dut (.*);
    adccb_reader u_rd (.clk(CLK_SYS), .cap_req(cap), .rd_req(rd),
        .we(WRITE_ENABLE), .re(READ_ENABLE));
    initial forever #12.5 CLK_SYS = ~CLK_SYS;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        SAMPLE_DATA <= $random(seed);
        SAMPLE_OVER_RANGE <= ($random(seed) & 63) == 0;
        if (RESET) begin
            q = {};
            ovm = 1'b0;
        end else begin
            if (CAPTURE_STROBE_SYNCED_OUT) begin
                nw++;
                if (!(ast && q.size() == 4096)) begin
                    if (q.size() == 4096) void'(q.pop_front());
                    q.push_back(SAMPLE_DATA);
                    ovm |= SAMPLE_OVER_RANGE;
                end
            end else if (READ_ENABLE) ovm = 1'b0;
            if (PRIMARY_DATA_VALID === 1'b1) begin
                chk(SECONDARY_DATA_VALID, two);
                if (two) chk(SECONDARY_OUTPUT_PORT, q.pop_front());
                chk(PRIMARY_OUTPUT_PORT, q.pop_front());
            end
        end
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        REG_WRITE <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WRITE <= 1'b0;
        if (a == 4'hF) begin
            two = d[12];
            ast = d[4];
        end
        @(posedge CLK_SYS);
        #1;
        chk(REG_RDATA, a == 4'hF ? d : 16'h0000);
        chk(SECONDARY_OUTPUT_OE_N, !two);
    endtask
    // Waits count synced strobe cycles, not queue pushes, so an auto-stopped capture still ends.
    task automatic run(input int n, input int left);
        int k;
        nw = 0;
        cap <= 1'b1;
        for (k = 0; k < 9000 && nw < n; k++) @(posedge CLK_SYS);
        cap <= 1'b0;
        if (nw < n) begin
            fail_count++;
            summarize();
        end
        repeat (6) @(posedge CLK_SYS);
        chk(OVER_RANGE, ovm);
        if (n > 4095) chk(BUFFER_FULL_FLAG, 1'b1);
        for (; k < 30000 && q.size() > left; k++) begin
            rd <= $random(seed);
            @(posedge CLK_SYS);
        end
        rd <= 1'b0;
        if (k >= 30000) begin
            fail_count++;
            summarize();
        end
        repeat (5) @(posedge CLK_SYS);
        chk({BUFFER_EMPTY_FLAG, BUFFER_FULL_FLAG}, {q.size() == 0, 1'b0});
        chk(OVER_RANGE, 1'b0);
    endtask
    task automatic rst_chk;
        repeat (16) @(posedge CLK_SYS);
        RESET <= 1'b0;
        two = 1'b0;
        ast = 1'b0;
        @(posedge CLK_SYS);
        #1;
        chk({BUFFER_EMPTY_FLAG, BUFFER_FULL_FLAG, OVER_RANGE}, 3'h4);
    endtask
    initial begin
        rst_chk();
        wr(4'h3, 16'hFFFF);
        wr(4'hF, 16'h0000);
        run(4100, 0);
        wr(4'hF, 16'h1000);
        run(9, 1);
        wr(4'hF, 16'h0010);
        run(4100, 0);
        RESET <= 1'b1;
        rst_chk();
        run(5, 0);
        summarize();
    end
endmodule
